// file: vc_remap_pkg.sv
// How it works
// - Raw-12 channel/type settings apply only in 12-bit raw input modes.
// - Bits 7:6 set raw-12 virtual channel; resets to receive port number.
// - Bits 5:0 set raw-12 data type; resets to 0x2C.
// - Virtual channel remap acts only in CSI-2 input mode.
// - Packet channel replaced by two-bit map entry selected by its channel.
// - Remap register resets to identity map 0xE4.
// - Last frame line count readable as high and low byte, reset zero.
// - With rows change enable set, line count freezes after update until read.
// - Reading line count high byte latches low byte; read high first.
// - Last frame line length readable; high byte register resets zero.
// - Reported line length is the last line of the frame.
// - With width change enable set, line length freezes after update until read.
// - Input mode codes: 00 CSI-2, 01 raw_12bit_input 50MHz, 10 raw_12bit_input 75MHz, 11 raw_10bit_input.
// - Line length low byte follows high byte and latches on high read.
package vc_remap_pkg;
    localparam logic [7:0] ADDR_RAW_WIDE = 8'h71;
    localparam logic [7:0] ADDR_VC_REMAP = 8'h72;
    localparam logic [7:0] ADDR_ROWS_HI = 8'h73;
    localparam logic [7:0] ADDR_ROWS_LO = 8'h74;
    localparam logic [7:0] ADDR_WIDTH_HI = 8'h75;
    localparam logic [7:0] ADDR_WIDTH_LO = 8'h76;
    localparam logic [7:0] ADDR_CTRL = 8'h7E;
    localparam logic [5:0] RAW_12BIT_INPUT_DTYPE_RST = 6'h2C;
    localparam logic [7:0] VC_REMAP_RST = 8'hE4;
    localparam int FIFO_DEPTH = 16;
    localparam int DATA_W = 8;

    typedef enum logic [1:0] {
        MODE_CSI2 = 2'b00,
        MODE_RAW_12BIT_INPUT_50 = 2'b01,
        MODE_RAW_12BIT_INPUT_75 = 2'b10,
        MODE_RAW_10BIT_INPUT_100 = 2'b11
    } serial_input_format_t;

    typedef struct packed {
        logic sof;
        logic eol;
        logic eof;
        logic [1:0] vchan;
        logic [5:0] dtype;
        logic [DATA_W-1:0] data;
    } beat_t;
endpackage

// file: vc_fifo.sv
`timescale 1ns/1ps
module vc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // vc_fifo

// file: vc_remap_and_line_stats.sv
`timescale 1ns/1ps
module vc_remap_and_line_stats #(
    parameter logic [1:0] RX_PORT = 2'd0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Configuration pins
    input wire vc_remap_pkg::serial_input_format_t serial_input_format,
    input wire logic rows_change_irq_en,
    input wire logic width_change_irq_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Incoming video from the serial link
    input wire logic in_valid,
    output logic in_ready,
    input wire vc_remap_pkg::beat_t in_beat,
    // Outgoing CSI-2 stream
    output logic out_valid,
    input wire logic out_ready,
    output vc_remap_pkg::beat_t out_beat,
    // Change events
    output logic rows_changed,
    output logic width_changed
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] raw_wide_vchan;
    logic [5:0] raw_wide_dtype;
    logic [7:0] vchan_remap;
    logic raw_12bit_input;
    logic csi_input;
    vc_remap_pkg::beat_t next_beat;
    logic fifo_valid;
    logic [$bits(vc_remap_pkg::beat_t)-1:0] fifo_data;
    vc_remap_pkg::beat_t fifo_beat;
    logic take;
    logic [3:0] cfg_pin;
    logic [3:0] cfg_s1;
    logic [3:0] cfg_s2;
    logic [3:0] cfg_s3;
    logic [3:0] cfg_q;
    vc_remap_pkg::serial_input_format_t mode_q;
    logic rows_en_q;
    logic width_en_q;

    // Mode and enables are pins; a level counts only once the two late stages agree
    assign cfg_pin = {serial_input_format, rows_change_irq_en, width_change_irq_en};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_s1 <= '0;
            cfg_s2 <= '0;
            cfg_s3 <= '0;
        end else begin
            cfg_s1 <= cfg_pin;
            cfg_s2 <= cfg_s1;
            cfg_s3 <= cfg_s2;
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_cfg
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    cfg_q[i] <= 1'b0;
                end else if (cfg_s2[i] == cfg_s3[i]) begin
                    cfg_q[i] <= cfg_s3[i];
                end
            end
        end
    endgenerate

    assign mode_q = vc_remap_pkg::serial_input_format_t'(cfg_q[3:2]);
    assign rows_en_q = cfg_q[1];
    assign width_en_q = cfg_q[0];

    assign raw_12bit_input = mode_q == vc_remap_pkg::MODE_RAW_12BIT_INPUT_50
        || mode_q == vc_remap_pkg::MODE_RAW_12BIT_INPUT_75;
    assign csi_input = mode_q == vc_remap_pkg::MODE_CSI2;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            raw_wide_vchan <= RX_PORT;
            raw_wide_dtype <= vc_remap_pkg::RAW_12BIT_INPUT_DTYPE_RST;
            vchan_remap <= vc_remap_pkg::VC_REMAP_RST;
        end else if (reg_wr) begin
            if (reg_addr == vc_remap_pkg::ADDR_RAW_WIDE) begin
                raw_wide_vchan <= reg_wdata[7:6];
                raw_wide_dtype <= reg_wdata[5:0];
            end
            if (reg_addr == vc_remap_pkg::ADDR_VC_REMAP) begin
                vchan_remap <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Header rewrite happens before the FIFO so a map change never splits a packet already queued
    always_comb begin
        next_beat = in_beat;
        if (raw_12bit_input) begin
            next_beat.vchan = raw_wide_vchan;
            next_beat.dtype = raw_wide_dtype;
        end else if (csi_input) begin
            next_beat.vchan = vchan_remap[{in_beat.vchan, 1'b0} +: 2];
        end
    end

    vc_fifo #(
        .WIDTH($bits(vc_remap_pkg::beat_t)),
        .DEPTH(vc_remap_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(next_beat),
        .out_valid(fifo_valid),
        .out_ready(take),
        .out_data(fifo_data)
    );

    assign fifo_beat = fifo_data;
    // Output stage register: refilled when empty or being consumed
    assign take = fifo_valid && (!out_valid || out_ready);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_beat <= '0;
        end else if (take) begin
            out_valid <= 1'b1;
            out_beat <= fifo_beat;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement on beats leaving the block, so counts match the emitted frame
    logic [15:0] row_cnt;
    logic [15:0] width_cnt;
    logic sent;

    assign sent = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            row_cnt <= '0;
            width_cnt <= '0;
        end else if (sent) begin
            if (out_beat.eol || out_beat.eof) begin
                width_cnt <= '0;
            end else begin
                width_cnt <= width_cnt + 16'd1;
            end
            if (out_beat.eof) begin
                row_cnt <= '0;
            end else if (out_beat.eol) begin
                row_cnt <= row_cnt + 16'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] frame_rows;
    logic [15:0] row_width;
    logic rows_frozen;
    logic width_frozen;
    logic [7:0] frame_rows_lower;
    logic [7:0] row_width_lower;
    logic frame_end;
    logic [15:0] rows_final;
    logic rd_rows_hi;
    logic rd_rows_lo;
    logic rd_width_hi;
    logic rd_width_lo;

    assign frame_end = sent && out_beat.eof;
    // The last line of a frame ends on the eof beat, so it counts as a row
    assign rows_final = row_cnt + 16'd1;
    assign rd_rows_hi = reg_rd && reg_addr == vc_remap_pkg::ADDR_ROWS_HI;
    assign rd_rows_lo = reg_rd && reg_addr == vc_remap_pkg::ADDR_ROWS_LO;
    assign rd_width_hi = reg_rd && reg_addr == vc_remap_pkg::ADDR_WIDTH_HI;
    assign rd_width_lo = reg_rd && reg_addr == vc_remap_pkg::ADDR_WIDTH_LO;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_rows <= '0;
            rows_frozen <= 1'b0;
            rows_changed <= 1'b0;
        end else begin
            rows_changed <= 1'b0;
            if (frame_end && !rows_frozen) begin
                frame_rows <= rows_final;
                rows_changed <= rows_final != frame_rows;
                rows_frozen <= rows_en_q;
            end else if (rd_rows_hi || rd_rows_lo || !rows_en_q) begin
                rows_frozen <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            row_width <= '0;
            width_frozen <= 1'b0;
            width_changed <= 1'b0;
        end else begin
            width_changed <= 1'b0;
            if (frame_end && !width_frozen) begin
                row_width <= width_cnt + 16'd1;
                width_changed <= (width_cnt + 16'd1) != row_width;
                width_frozen <= width_en_q;
            end else if (rd_width_hi || rd_width_lo || !width_en_q) begin
                width_frozen <= 1'b0;
            end
        end
    end

    // Low bytes are shadowed on a high-byte read so both halves come from one value
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_rows_lower <= '0;
            row_width_lower <= '0;
        end else begin
            if (rd_rows_hi) begin
                frame_rows_lower <= frame_rows[7:0];
            end
            if (rd_width_hi) begin
                row_width_lower <= row_width[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                vc_remap_pkg::ADDR_RAW_WIDE: reg_rdata <= {raw_wide_vchan, raw_wide_dtype};
                vc_remap_pkg::ADDR_VC_REMAP: reg_rdata <= vchan_remap;
                vc_remap_pkg::ADDR_ROWS_HI: reg_rdata <= frame_rows[15:8];
                vc_remap_pkg::ADDR_ROWS_LO: reg_rdata <= frame_rows_lower;
                vc_remap_pkg::ADDR_WIDTH_HI: reg_rdata <= row_width[15:8];
                vc_remap_pkg::ADDR_WIDTH_LO: reg_rdata <= row_width_lower;
                vc_remap_pkg::ADDR_CTRL: reg_rdata <= {4'h0, rows_frozen, width_frozen,
                    mode_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // vc_remap_and_line_stats

// file: vc_remap_checker.sv
`timescale 1ns/1ps
module vc_remap_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Output stream and events
    input wire logic out_valid,
    input wire logic out_ready,
    input wire vc_remap_pkg::beat_t out_beat,
    input wire logic rows_changed,
    input wire logic width_changed
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic eof_hs;
    assign eof_hs = out_valid && out_ready && out_beat.eof;
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    AST_RD_UNMAPPED: assert property (reg_rd && !(reg_addr inside {[8'h71:8'h76], 8'h7E}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_REMAP_RW: assert property (wr_at(8'h72) ##2 rd_at(8'h72) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("remap register readback wrong");
    AST_RAW_RW: assert property (wr_at(8'h71) ##2 rd_at(8'h71) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("raw channel register readback wrong");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
        else $error("output beat changed while stalled");
    AST_ROWS_CAUSE: assert property (rows_changed |-> $past(eof_hs) || $past(eof_hs, 2))
        else $error("row change without frame end");
    AST_WIDTH_CAUSE: assert property (width_changed |-> $past(eof_hs) || $past(eof_hs, 2))
        else $error("width change without frame end");
    AST_ROWS_PULSE: assert property (rows_changed |=> !rows_changed)
        else $error("row change event longer than one cycle");
endmodule // vc_remap_checker

bind vc_remap_and_line_stats vc_remap_checker i_chk (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .out_valid, .out_ready, .out_beat, .rows_changed, .width_changed);

// file: vc_link_model.sv
`timescale 1ns/1ps
module vc_link_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Link side of the receive port
    input wire logic in_ready,
    output logic in_valid,
    output vc_remap_pkg::beat_t in_beat
);
    vc_remap_pkg::beat_t q[$];
    int gap = 0;
    int wait_n = 0;
    initial begin
        in_valid = 1'b0;
        in_beat = '0;
    end
    // Released bus shows the inverted beat so stale data never looks valid
    always @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            in_valid <= 1'b0;
            in_beat <= ~in_beat;
            wait_n <= gap;
        end else if (!in_valid && wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (!in_valid && !srst && q.size() > 0) begin
            in_valid <= 1'b1;
            in_beat <= q.pop_front();
        end
    end
endmodule // vc_link_model

// file: test_vc_remap_and_line_stats.sv
`timescale 1ns/1ps
module test_vc_remap_and_line_stats;
    logic clk_sys, srst, rows_en, width_en, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
    logic rows_changed, width_changed;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [15:0] v;
    vc_remap_pkg::serial_input_format_t mode;
    vc_remap_pkg::beat_t in_beat, out_beat, b;
    vc_remap_pkg::beat_t got[$];
    int mismatches = 0;
    int n_checks = 0;
    int n_pulse = 0;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    vc_remap_and_line_stats i_dut (.clk_sys, .srst, .serial_input_format(mode), .rows_change_irq_en(rows_en),
        .width_change_irq_en(width_en), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
        .in_ready, .in_beat, .out_valid, .out_ready, .out_beat, .rows_changed, .width_changed);
    vc_link_model i_link (.clk_sys, .srst, .in_ready, .in_valid, .in_beat);
    always @(posedge clk_sys) begin
        if (out_valid && out_ready) got.push_back(out_beat);
        if (rows_changed || width_changed) n_pulse++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task rd16(input logic [7:0] a, output logic [15:0] r);
        rd(a, r[15:8]);
        rd(a + 8'h01, r[7:0]);
    endtask
    // Bounded wait; the answer lags the input by a few cycles
    task settle();
        for (int i = 0; i < 4000 && (i_link.q.size() > 0 || in_valid || out_valid); i++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
    endtask
    // First line is longer so only the last line may set the width
    task frame(input int rows, input int len);
        int n;
        for (int r = 0; r < rows; r++) begin
            n = (r == 0) ? len + 3 : len;
            for (int k = 0; k < n; k++) begin
                b = '0;
                b.sof = (r == 0 && k == 0);
                b.data = 8'(k);
                b.eol = (k == n - 1 && r < rows - 1);
                b.eof = (k == n - 1 && r == rows - 1);
                i_link.q.push_back(b);
            end
        end
        settle();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset();
        logic [7:0] ra[5] = '{8'h73, 8'h74, 8'h75, 8'h76, 8'h50};
        rd(8'h71, d);
        check("raw_wide_channel_type", d, 16'h002C);
        rd(8'h72, d);
        check("virtual_channel_remap", d, 16'h00E4);
        wr(8'h73, 8'hA5);
        foreach (ra[i]) begin
            rd(ra[i], d);
            check("count_regs", d, 16'h0000);
        end
    endtask
    task t_modes();
        wr(8'h71, 8'hD5);
        rd(8'h71, d);
        check("raw_wide_rw", d, 16'h00D5);
        wr(8'h72, 8'h1B);
        rd(8'h72, d);
        check("remap_rw", d, 16'h001B);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            mode <= vc_remap_pkg::serial_input_format_t'(m);
            repeat (6) @(posedge clk_sys);
            got.delete();
            for (int c = 0; c < 4; c++) begin
                b = '0;
                b.vchan = 2'(c);
                b.dtype = 6'h2B;
                b.eof = (c == 3);
                i_link.q.push_back(b);
            end
            settle();
            check("beats", 16'(got.size()), 16'h0004);
            foreach (got[i]) begin
                check("vchan", got[i].vchan, 16'(m == 0 ? 3 - i : (m == 3 ? i : 3)));
                check("dtype", got[i].dtype, (m == 1 || m == 2) ? 16'h0015 : 16'h002B);
            end
        end
    endtask
    task t_stats();
        mode <= vc_remap_pkg::MODE_CSI2;
        n_pulse = 0;
        frame(257, 1);
        rd16(8'h73, v);
        check("rows", v, 16'h0101);
        frame(2, 259);
        rd16(8'h73, v);
        check("rows", v, 16'h0002);
        rd16(8'h75, v);
        check("width", v, 16'h0103);
        check("change_events", 16'(n_pulse > 0), 16'h0001);
    endtask
    task t_latch();
        i_link.gap = 3;
        frame(3, 5);
        rd(8'h73, d);
        rd(8'h75, d);
        frame(6, 7);
        rd(8'h74, d);
        check("rows_low_latched", d, 16'h0003);
        rd(8'h76, d);
        check("width_low_latched", d, 16'h0005);
        i_link.gap = 0;
    endtask
    task t_freeze();
        @(posedge clk_sys);
        rows_en <= 1'b1;
        width_en <= 1'b1;
        frame(4, 6);
        frame(2, 3);
        rd(8'h7E, d);
        check("freeze_status", d, 16'h000C);
        rd16(8'h73, v);
        check("rows_frozen", v, 16'h0004);
        rd16(8'h75, v);
        check("width_frozen", v, 16'h0006);
        frame(2, 3);
        rd16(8'h73, v);
        check("rows_after_read", v, 16'h0002);
        rd16(8'h75, v);
        check("width_after_read", v, 16'h0003);
    endtask
    task t_fifo();
        out_ready <= 1'b0;
        got.delete();
        for (int i = 0; i < 20; i++) begin
            b = '0;
            b.data = 8'(i);
            b.eof = (i == 19);
            i_link.q.push_back(b);
        end
        repeat (60) @(posedge clk_sys);
        check("full_refused", {in_valid, in_ready}, 16'h0002);
        out_ready <= 1'b1;
        settle();
        check("drained", 16'(got.size()), 16'h0014);
        foreach (got[i]) check("order", got[i].data, 16'(i));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task complete_run();
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
    initial begin
        srst = 1'b1;
        mode = vc_remap_pkg::MODE_CSI2;
        rows_en = 1'b0;
        width_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        out_ready = 1'b1;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_modes();
        t_stats();
        t_latch();
        t_freeze();
        t_fifo();
        complete_run();
    end
endmodule // test_vc_remap_and_line_stats
